// ---- rtl/dcw_top.sv ----
// Control word decoder and phase path of a small waveform generator.
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Selected phase offset register is added to the accumulator output.
// - Selected tuning word register feeds the phase accumulator.
// - Soft reset bit holds accumulator and output at zero/midscale.
// - Clock halt bit freezes accumulator and output.
// - Power-down bit turns the converter off.
// - Top-bit enable routes the data MSB, or halved MSB, to output.
// - Top-bit enable low routes converter; wave bit picks sine or triangle.
// - Undivided bit picks MSB directly, else MSB divided by two.
// - Wave bit one gives triangle, zero gives parabola sine approximation output.
// - Split loading with half select one writes upper 14 bits only.
// - Half select is ignored while full-word load is set.
// - Split loading with half select zero writes lower 14 bits only.
// - Full-word load commits both halves together after the second write.
module dcw_top
  import dcw_pkg::*;
#(
  parameter int unsigned OUT_W = 10
)(
  input  wire logic             MCLK_I,
  input  wire logic             RST_N_I,
  input  wire logic             PSEL_I,
  input  wire logic             PENABLE_I,
  input  wire logic             PWRITE_I,
  input  wire logic [11:0]      PADDR_I,
  input  wire logic [31:0]      PWDATA_I,
  output logic      [31:0]      PRDATA_O,
  output logic                  PREADY_O,
  output logic                  PSLVERR_O,
  output logic      [OUT_W-1:0] WAVE_DATA_O,
  output logic                  TOP_BIT_O,
  output logic                  TOP_BIT_MODE_O,
  output logic                  CONVERTER_ON_O
);
  import dcw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode.

  dcw_apb_req_t req;
  assign req = '{PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I};

  logic [15:0]       ctrl_word;
  logic [FREQ_W-1:0] tuning_word_reg_0;
  logic [FREQ_W-1:0] tuning_word_reg_1;
  logic [PHASE_W-1:0] phase_offset_reg_0;
  logic [PHASE_W-1:0] phase_offset_reg_1;
  logic [HALF_W-1:0] pend_low;
  logic              pend_valid;
  logic              pend_reg;
  logic [FREQ_W-1:0] acc;
  logic              div_flop;

  wire setup    = req.psel && !req.penable;
  // A write acts only at the edge where the slave shows ready.
  wire access   = req.psel && req.penable && PREADY_O;
  wire wr_ev    = access && req.pwrite;
  wire hit_ctrl = req.paddr == OFS_CTRL;
  wire hit_f0   = req.paddr == OFS_TUNING_WORD_REG_0;
  wire hit_f1   = req.paddr == OFS_TUNING_WORD_REG_1;
  wire hit_p0   = req.paddr == OFS_PHASE_OFFSET_REG_0;
  wire hit_p1   = req.paddr == OFS_PHASE_OFFSET_REG_1;
  wire hit_st   = req.paddr == OFS_STATUS;
  wire hit_acc  = req.paddr == OFS_ACC;
  wire hit_any  = hit_ctrl | hit_f0 | hit_f1 | hit_p0 | hit_p1
                | hit_st | hit_acc;

  // The whole 16-bit word is taken in one access, so a half word never acts.
  dcw_ctrl_t ctl;
  assign ctl = dcw_decode(ctrl_word);

  wire [HALF_W-1:0] wdat = req.pwdata[HALF_W-1:0];
  wire freq_wr = wr_ev && (hit_f0 || hit_f1);
  wire sel1    = hit_f1;

  ////////////////////////////////////////////////////////////////////////////
  // Frequency loading: split halves or paired full word.

  wire full_commit = freq_wr && ctl.full_word_load && pend_valid
                     && (pend_reg == sel1);
  wire full_first  = freq_wr && ctl.full_word_load && !full_commit;
  wire split_hi    = freq_wr && !ctl.full_word_load && ctl.half_select;
  wire split_lo    = freq_wr && !ctl.full_word_load && !ctl.half_select;

  function automatic logic [FREQ_W-1:0] next_tuning(
    input logic [FREQ_W-1:0] cur,
    input logic              hit,
    input logic              commit,
    input logic              hi,
    input logic              lo,
    input logic [HALF_W-1:0] d,
    input logic [HALF_W-1:0] low);
    logic [FREQ_W-1:0] v;
    v = cur;
    if (hit && commit)
      v = {d, low};
    else if (hit && hi)
      v = {d, cur[HALF_W-1:0]};
    else if (hit && lo)
      v = {cur[FREQ_W-1:HALF_W], d};
    return v;
  endfunction : next_tuning

  // Every operand is passed in: a continuous assignment wakes only on
  // the arguments it hands over, not on what a function body reaches for.
  wire [FREQ_W-1:0] next_f0 = next_tuning(tuning_word_reg_0, hit_f0,
    full_commit, split_hi, split_lo, wdat, pend_low);
  wire [FREQ_W-1:0] next_f1 = next_tuning(tuning_word_reg_1, hit_f1,
    full_commit, split_hi, split_lo, wdat, pend_low);

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      ctrl_word          <= CTRL_RESET;
      tuning_word_reg_0  <= '0;
      tuning_word_reg_1  <= '0;
      phase_offset_reg_0 <= '0;
      phase_offset_reg_1 <= '0;
      pend_low           <= '0;
      pend_valid         <= 1'b0;
      pend_reg           <= 1'b0;
    end
    else
    begin
      if (wr_ev && hit_ctrl)
      begin
        ctrl_word <= req.pwdata[WORD_W-1:0];
        pend_valid <= 1'b0;
      end
      else if (full_first)
      begin
        pend_low   <= wdat;
        pend_valid <= 1'b1;
        pend_reg   <= sel1;
      end
      else if (full_commit)
        pend_valid <= 1'b0;
      tuning_word_reg_0 <= next_f0;
      tuning_word_reg_1 <= next_f1;
      if (wr_ev && hit_p0)
        phase_offset_reg_0 <= req.pwdata[PHASE_W-1:0];
      if (wr_ev && hit_p1)
        phase_offset_reg_1 <= req.pwdata[PHASE_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase accumulator and output path.

  wire [FREQ_W-1:0] step = ctl.freq_reg_select ? tuning_word_reg_1
                                               : tuning_word_reg_0;
  wire [PHASE_W-1:0] poff = ctl.phase_reg_select ? phase_offset_reg_1
                                                 : phase_offset_reg_0;
  wire [PHASE_W-1:0] phase = acc[FREQ_W-1 -: PHASE_W] + poff;
  wire               run   = !ctl.soft_reset && !ctl.clock_halt;

  // Triangle folds the phase; the sine is a quarter-wave parabola
  // approximation, traded for table area since the level is not exact.
  wire [PHASE_W-2:0] fold = phase[PHASE_W-1] ? ~phase[PHASE_W-2:0]
                                             : phase[PHASE_W-2:0];
  wire [OUT_W-1:0] tri_v = fold[PHASE_W-2 -: OUT_W];
  wire [PHASE_W-2:0] q = phase[PHASE_W-2] ? {~phase[PHASE_W-3:0], 1'b0}
                                          : {phase[PHASE_W-3:0], 1'b0};
  wire [2*PHASE_W-3:0] sq = (2*PHASE_W-2)'(q) * (2*PHASE_W-2)'(q);
  // The curve is 2x - x*x on the quarter wave; its top 22 codes
  // overflow the magnitude field, so they saturate there.
  wire [PHASE_W-1:0] para = {q, 1'b0}
                          - {1'b0, sq[2*PHASE_W-3 -: PHASE_W-1]};
  wire [OUT_W-2:0] mag = para[PHASE_W-1] ? '1
                                         : para[PHASE_W-2 -: OUT_W-1];
  wire [OUT_W-1:0] sin_v = phase[PHASE_W-1] ? {1'b0, ~mag} : {1'b1, mag};
  wire [OUT_W-1:0] wav = ctl.wave_triangle ? tri_v : sin_v;
  wire [OUT_W-1:0] midscale = {1'b1, {(OUT_W-1){1'b0}}};
  logic acc_msb_q;
  wire msb_rise = phase[PHASE_W-1] && !acc_msb_q;

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I || ctl.soft_reset)
    begin
      acc         <= '0;
      acc_msb_q   <= 1'b0;
      div_flop    <= 1'b0;
      WAVE_DATA_O <= midscale;
      TOP_BIT_O   <= 1'b0;
    end
    else if (run)
    begin
      acc       <= acc + step;
      acc_msb_q <= phase[PHASE_W-1];
      if (msb_rise)
        div_flop <= ~div_flop;
      WAVE_DATA_O <= ctl.top_bit_output_enable ? midscale : wav;
      TOP_BIT_O   <= ctl.top_bit_output_enable &&
                     (ctl.top_bit_undivided ? phase[PHASE_W-1]
                                            : div_flop);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs and read data.

  wire [31:0] status = {29'h0000000, pend_valid, ctl.clock_halt,
                        ctl.soft_reset};
  wire [31:0] rdata = hit_ctrl ? {16'h0000, ctrl_word}
                    : hit_f0   ? {4'h0, tuning_word_reg_0}
                    : hit_f1   ? {4'h0, tuning_word_reg_1}
                    : hit_p0   ? {20'h00000, phase_offset_reg_0}
                    : hit_p1   ? {20'h00000, phase_offset_reg_1}
                    : hit_st   ? status
                    : hit_acc  ? {4'h0, acc}
                    : APB_ZERO;

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      PRDATA_O       <= APB_ZERO;
      PREADY_O       <= 1'b0;
      PSLVERR_O      <= 1'b0;
      TOP_BIT_MODE_O <= 1'b0;
      CONVERTER_ON_O <= 1'b1;
    end
    else
    begin
      PREADY_O  <= setup;
      PSLVERR_O <= setup && !hit_any;
      PRDATA_O  <= (setup && !req.pwrite) ? rdata : APB_ZERO;
      TOP_BIT_MODE_O <= ctl.top_bit_output_enable;
      CONVERTER_ON_O <= !ctl.converter_powerdown;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_reset_hold: assert property (
    @(posedge MCLK_I) disable iff (!RST_N_I)
    ctl.soft_reset |=> acc == '0 && WAVE_DATA_O == midscale)
    else $error("soft reset did not clear accumulator");
  a_halt_freeze: assert property (
    @(posedge MCLK_I) disable iff (!RST_N_I)
    ctl.clock_halt && !ctl.soft_reset && $stable(ctrl_word)
    |=> $stable(acc))
    else $error("accumulator moved while halted");
  a_halt_outputs: assert property (
    @(posedge MCLK_I) disable iff (!RST_N_I)
    ctl.clock_halt && !ctl.soft_reset
    |=> $stable(WAVE_DATA_O) && $stable(TOP_BIT_O))
    else $error("output moved while halted");
  a_acc_step: assert property (
    @(posedge MCLK_I) disable iff (!RST_N_I)
    run |=> acc == $past(acc) + $past(step))
    else $error("accumulator step wrong");
  a_pd_follow: assert property (
    @(posedge MCLK_I) disable iff (!RST_N_I)
    ##1 CONVERTER_ON_O == !$past(ctl.converter_powerdown))
    else $error("power-down not followed");
  a_mode_follow: assert property (
    @(posedge MCLK_I) disable iff (!RST_N_I)
    ##1 TOP_BIT_MODE_O == $past(ctl.top_bit_output_enable))
    else $error("top-bit mode flag not followed");
  a_top_mode: assert property (
    @(posedge MCLK_I) disable iff (!RST_N_I)
    run && ctl.top_bit_output_enable |=> WAVE_DATA_O == midscale)
    else $error("converter not disconnected");
  a_top_undiv: assert property (
    @(posedge MCLK_I) disable iff (!RST_N_I)
    run && ctl.top_bit_output_enable && ctl.top_bit_undivided
    |=> TOP_BIT_O == $past(phase[PHASE_W-1]))
    else $error("undivided top bit wrong");
  a_top_div: assert property (
    @(posedge MCLK_I) disable iff (!RST_N_I)
    run && ctl.top_bit_output_enable && !ctl.top_bit_undivided
    |=> TOP_BIT_O == $past(div_flop))
    else $error("halved top bit wrong");
  a_top_off: assert property (
    @(posedge MCLK_I) disable iff (!RST_N_I)
    run && !ctl.top_bit_output_enable |=> !TOP_BIT_O)
    else $error("top bit driven outside top-bit mode");
  a_wave_tri: assert property (
    @(posedge MCLK_I) disable iff (!RST_N_I)
    run && !ctl.top_bit_output_enable && ctl.wave_triangle
    |=> WAVE_DATA_O == $past(tri_v))
    else $error("triangle not selected");
  a_wave_sine: assert property (
    @(posedge MCLK_I) disable iff (!RST_N_I)
    run && !ctl.top_bit_output_enable && !ctl.wave_triangle
    |=> WAVE_DATA_O == $past(sin_v))
    else $error("sine not selected");
  a_split_hi: assert property (
    @(posedge MCLK_I) disable iff (!RST_N_I)
    split_hi && hit_f0 |=> tuning_word_reg_0[HALF_W-1:0]
    == $past(tuning_word_reg_0[HALF_W-1:0]))
    else $error("upper half write touched lower bits");
  a_split_hi_f1: assert property (
    @(posedge MCLK_I) disable iff (!RST_N_I)
    split_hi && hit_f1 |=> tuning_word_reg_1
    == {$past(wdat), $past(tuning_word_reg_1[HALF_W-1:0])})
    else $error("upper half write to second register wrong");
  a_split_lo: assert property (
    @(posedge MCLK_I) disable iff (!RST_N_I)
    split_lo && hit_f0 |=> tuning_word_reg_0[FREQ_W-1:HALF_W]
    == $past(tuning_word_reg_0[FREQ_W-1:HALF_W]))
    else $error("lower half write touched upper bits");
  a_split_lo_f1: assert property (
    @(posedge MCLK_I) disable iff (!RST_N_I)
    split_lo && hit_f1 |=> tuning_word_reg_1
    == {$past(tuning_word_reg_1[FREQ_W-1:HALF_W]), $past(wdat)})
    else $error("lower half write to second register wrong");
  a_full_hold: assert property (
    @(posedge MCLK_I) disable iff (!RST_N_I)
    full_first && hit_f0 |=> $stable(tuning_word_reg_0))
    else $error("intermediate full word exposed");
  a_full_hold_f1: assert property (
    @(posedge MCLK_I) disable iff (!RST_N_I)
    full_first && hit_f1 |=> $stable(tuning_word_reg_1))
    else $error("intermediate full word exposed on second register");
  a_full_commit: assert property (
    @(posedge MCLK_I) disable iff (!RST_N_I)
    full_commit && hit_f0 |=> tuning_word_reg_0
    == {$past(wdat), $past(pend_low)})
    else $error("full word commit wrong");
  a_ctrl_word: assert property (
    @(posedge MCLK_I) disable iff (!RST_N_I)
    wr_ev && hit_ctrl |=> ctrl_word == $past(req.pwdata[WORD_W-1:0]))
    else $error("control word not taken whole");
  a_bus_answer: assert property (
    @(posedge MCLK_I) disable iff (!RST_N_I)
    setup |=> PREADY_O && PSLVERR_O == !$past(hit_any))
    else $error("bus answer wrong");
  a_phase_sel: assert property (
    @(posedge MCLK_I) disable iff (!RST_N_I)
    phase == PHASE_W'(acc[FREQ_W-1 -: PHASE_W] + (ctl.phase_reg_select
    ? phase_offset_reg_1 : phase_offset_reg_0)))
    else $error("phase offset selection wrong");

  c_full_load: cover property (@(posedge MCLK_I) full_commit);
  c_split_hi:  cover property (@(posedge MCLK_I) split_hi);
  c_top_div:   cover property (@(posedge MCLK_I)
    run && ctl.top_bit_output_enable && !ctl.top_bit_undivided);
  c_halt:      cover property (@(posedge MCLK_I) ctl.clock_halt);
  c_wave_tri:  cover property (@(posedge MCLK_I)
    run && !ctl.top_bit_output_enable && ctl.wave_triangle);

endmodule : dcw_top
`default_nettype wire

// ---- rtl/dcw_pkg.sv ----
// Package for the control word decoder: field positions, widths and types.
package dcw_pkg;
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned HALF_W   = 14;
  localparam int unsigned FREQ_W   = 28;
  localparam int unsigned PHASE_W  = 12;
  localparam int unsigned ADDR_W   = 12;
  // Field positions inside the 16-bit control word.
  localparam int unsigned BIT_FULL = 13;
  localparam int unsigned BIT_HALF = 12;
  localparam int unsigned BIT_FSEL = 11;
  localparam int unsigned BIT_PSEL = 10;
  localparam int unsigned BIT_RST  = 8;
  localparam int unsigned BIT_HALT = 7;
  localparam int unsigned BIT_PD   = 6;
  localparam int unsigned BIT_TOP  = 5;
  localparam int unsigned BIT_UNDV = 3;
  localparam int unsigned BIT_WAVE = 1;
  // APB byte offsets.
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_TUNING_WORD_REG_0  = 12'h004;
  localparam logic [11:0] OFS_TUNING_WORD_REG_1  = 12'h008;
  localparam logic [11:0] OFS_PHASE_OFFSET_REG_0 = 12'h00C;
  localparam logic [11:0] OFS_PHASE_OFFSET_REG_1 = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_ACC    = 12'h018;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [31:0] APB_ZERO   = 32'h0000_0000;

  typedef struct packed {
    logic full_word_load;
    logic half_select;
    logic freq_reg_select;
    logic phase_reg_select;
    logic soft_reset;
    logic clock_halt;
    logic converter_powerdown;
    logic top_bit_output_enable;
    logic top_bit_undivided;
    logic wave_triangle;
  } dcw_ctrl_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dcw_apb_req_t;

  function automatic dcw_ctrl_t dcw_decode(input logic [15:0] w);
    dcw_ctrl_t c;
    c.full_word_load        = w[BIT_FULL];
    c.half_select           = w[BIT_HALF];
    c.freq_reg_select       = w[BIT_FSEL];
    c.phase_reg_select      = w[BIT_PSEL];
    c.soft_reset            = w[BIT_RST];
    c.clock_halt            = w[BIT_HALT];
    c.converter_powerdown   = w[BIT_PD];
    c.top_bit_output_enable = w[BIT_TOP];
    c.top_bit_undivided     = w[BIT_UNDV];
    c.wave_triangle         = w[BIT_WAVE];
    return c;
  endfunction : dcw_decode
endpackage : dcw_pkg

// ---- bench/dcw_host_model.sv ----
// Host model: an APB master that also keeps the host's control-word duties.
`timescale 1ns/1ps
`default_nettype none
module dcw_host_model
  import dcw_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic [31:0]           prdata_i,
  input  wire logic                  pready_i,
  input  wire logic                  pslverr_i,
  output var  dcw_pkg::dcw_apb_req_t req_o
);
  logic [15:0] shadow;
  initial req_o = '0;
  initial shadow = CTRL_RESET;
  //////////////////////////////////////////////////////////////////////////
  // The wait has no limit of its own: only the bench watchdog ends it.
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
    @(posedge clk_i);
    req_o <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk_i);
    req_o.penable <= 1'b1;
    do
      @(posedge clk_i);
    while (pready_i !== 1'b1);
    rd = prdata_i;
    err = pslverr_i;
    req_o <= '0;
  endtask : xfer
  task automatic put_ctrl(input logic [15:0] w);
    logic [31:0] rd;
    logic        e;
    shadow = w & 16'hFDEB;
    if (shadow[BIT_TOP])
      shadow[BIT_WAVE] = 1'b0;
    xfer(1'b1, OFS_CTRL, {16'h0000, shadow}, rd, e);
  endtask : put_ctrl
  task automatic freq_split(input logic sel, input logic hi,
                            input logic [13:0] v);
    logic [31:0] rd;
    logic        e;
    put_ctrl((shadow & 16'hCFFF) | (hi ? 16'h1000 : 16'h0000));
    xfer(1'b1, sel ? OFS_TUNING_WORD_REG_1 : OFS_TUNING_WORD_REG_0, {18'h00000, v}, rd, e);
  endtask : freq_split
endmodule : dcw_host_model
`default_nettype wire

// ---- bench/test_dds_control_word_decode.sv ----
// Self-checking bench for the control word decoder.
`timescale 1ns/1ps
`default_nettype none
module test_dds_control_word_decode;
  import dcw_pkg::*;
  logic         mclk;
  logic         rst_n;
  dcw_apb_req_t req;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [9:0]   wave;
  logic         top_bit;
  logic         top_mode;
  logic         conv_on;
  int           bad_count;
  int           samples_checked;
  dcw_top #(.OUT_W(10)) dcw_top_inst (
    .MCLK_I(mclk), .RST_N_I(rst_n), .PSEL_I(req.psel),
    .PENABLE_I(req.penable), .PWRITE_I(req.pwrite), .PADDR_I(req.paddr),
    .PWDATA_I(req.pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .WAVE_DATA_O(wave), .TOP_BIT_O(top_bit),
    .TOP_BIT_MODE_O(top_mode), .CONVERTER_ON_O(conv_on));
  dcw_host_model dcw_host_model_inst (
    .clk_i(mclk), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr), .req_o(req));
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic e;
    dcw_host_model_inst.xfer(1'b0, a, APB_ZERO, d, e);
  endtask : rd
  task automatic ctl(input logic [15:0] w);
    dcw_host_model_inst.put_ctrl(w);
    repeat (4) @(posedge mclk);
    #1;
  endtask : ctl
  // Two reads three cycles apart: the step equals three tuning words.
  task automatic rate(input logic [27:0] f);
    logic [31:0] a;
    logic [31:0] b;
    logic [27:0] d;
    rd(OFS_ACC, a);
    rd(OFS_ACC, b);
    d = b[27:0] - a[27:0];
    check({4'h0, d}, {4'h0, f + f + f});
  endtask : rate
  task automatic rises(input int exp);
    int   n;
    logic p;
    n = 0;
    p = top_bit;
    repeat (64)
    begin
      @(posedge mclk);
      #1;
      if (top_bit && !p)
        n++;
      p = top_bit;
    end
    check(n, exp);
  endtask : rises
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset_and_map;
    logic [31:0] d;
    logic        e;
    check({wave, top_bit, top_mode, conv_on}, 32'h0000_1001);
    dcw_host_model_inst.xfer(1'b0, 12'h01C, APB_ZERO, d, e);
    check({e, d[30:0]}, 32'h8000_0000);
  endtask : t_reset_and_map
  task automatic t_loading;
    logic [31:0] d;
    logic        e;
    dcw_host_model_inst.freq_split(1'b0, 1'b0, 14'h0005);
    rate(28'h0000005);
    dcw_host_model_inst.freq_split(1'b0, 1'b1, 14'h0001);
    rate(28'h0004005);
    ctl(16'h3000);
    dcw_host_model_inst.xfer(1'b1, OFS_TUNING_WORD_REG_0, 32'h0000_0003, d, e);
    rd(OFS_STATUS, d);
    check(d[2], 1);
    rate(28'h0004005);
    dcw_host_model_inst.xfer(1'b1, OFS_TUNING_WORD_REG_0, APB_ZERO, d, e);
    rate(28'h0000003);
    dcw_host_model_inst.freq_split(1'b1, 1'b0, 14'h0007);
    ctl(16'h0800);
    rate(28'h0000007);
    ctl(16'h0000);
    rate(28'h0000003);
  endtask : t_loading
  task automatic t_halt_pd;
    logic [31:0] d;
    logic [9:0]  w;
    ctl(16'h0080);
    rate(28'h0000000);
    w = wave;
    repeat (6) @(posedge mclk);
    check(wave, w);
    ctl(16'h0040);
    check(conv_on, 0);
    ctl(16'h0000);
    check(conv_on, 1);
    rate(28'h0000003);
  endtask : t_halt_pd
  task automatic t_top_bit;
    dcw_host_model_inst.freq_split(1'b0, 1'b1, 14'h0400);
    dcw_host_model_inst.freq_split(1'b0, 1'b0, 14'h0000);
    ctl(16'h0028);
    check({top_mode, wave}, 32'h0000_0600);
    rises(4);
    ctl(16'h0022);
    rises(2);
    ctl(16'h0000);
    check({top_mode, top_bit}, 0);
  endtask : t_top_bit
  task automatic t_phase;
    logic [31:0] d;
    logic        e;
    logic [9:0]  w;
    dcw_host_model_inst.freq_split(1'b0, 1'b1, 14'h0000);
    ctl(16'h0100);
    check(wave, 10'h200);
    rd(OFS_ACC, d);
    check(d, 0);
    ctl(16'h0000);
    dcw_host_model_inst.xfer(1'b1, OFS_PHASE_OFFSET_REG_0, 32'h0000_0100, d, e);
    dcw_host_model_inst.xfer(1'b1, OFS_PHASE_OFFSET_REG_1, 32'h0000_0800, d, e);
    ctl(16'h0000);
    w = wave;
    ctl(16'h0400);
    check(wave !== w, 1);
    ctl(16'h0000);
    w = wave;
    ctl(16'h0002);
    check(wave !== w, 1);
  endtask : t_phase
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    bad_count = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    t_reset_and_map();
    t_loading();
    t_halt_pd();
    t_top_bit();
    t_phase();
    wrap_up();
  end
  initial
  begin
    #200000;
    bad_count++;
    wrap_up();
  end
endmodule : test_dds_control_word_decode
`default_nettype wire
